// ### mwce_pkg.sv
// Shared constants and types of the macro word command expander.
package mwce_pkg;

	// ****************************************************************
	// Sizes of the macro store
	// ****************************************************************
	localparam int NSLOT     = 8;
	localparam int SLOT_W    = 3;
	localparam int BODY_LEN  = 32;
	localparam int BODY_AW   = 5;
	localparam int MEM_AW    = SLOT_W + BODY_AW;
	localparam int MEM_DEPTH = NSLOT * BODY_LEN;
	localparam int NAME_LEN  = 8;
	localparam logic [5:0] BODY_FULL = 6'(BODY_LEN);
	localparam logic [3:0] TOK_FULL  = 4'(NAME_LEN);

	// ****************************************************************
	// Values after reset
	// ****************************************************************
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic       RECOG_BLANK = 1'b1;

	// ****************************************************************
	// Characters
	// ****************************************************************
	localparam logic [7:0] CH_NUL  = 8'h00;
	localparam logic [7:0] CH_SP   = 8'h20;
	localparam logic [7:0] CH_CR   = 8'h0D;
	localparam logic [7:0] CH_LF   = 8'h0A;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_WILD = 8'h24;
	localparam logic [7:0] CH_EXEC = 8'h58;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;

	// ****************************************************************
	// Reserved words, right aligned as the token register holds them
	// ****************************************************************
	localparam logic [63:0] KW_DEFINE     = 64'h0000_0041_4C49_4153;
	localparam logic [63:0] KW_MARK_ON    = 64'h0000_0000_004E_4557;
	localparam logic [63:0] KW_RECOG_OFF  = 64'h0000_0000_004F_4C44;
	localparam logic [63:0] KW_SAVE       = 64'h0000_0000_5341_5645;
	localparam logic [63:0] KW_LIST       = 64'h0000_0000_4C49_5354;
	localparam logic [63:0] KW_PURGE      = 64'h0000_464F_5247_4554;
	localparam logic [63:0] KW_STATUS_SEL = 64'h0000_0000_0000_5532;
	localparam logic [63:0] KW_STATUS_SX  = 64'h0000_0000_0055_3258;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic [63:0] name;
		logic [5:0]  len;
		logic        wild;
	} mwce_slot_s;

	typedef struct packed {
		logic                    recog;
		logic [3:0]              count;
		mwce_slot_s [NSLOT-1:0]  slots;
	} mwce_image_s;

endpackage : mwce_pkg

// ### mwce_nv_store.sv
// Nonvolatile image of the macro store and the recognition mode.
`timescale 1ns/10ps
module mwce_nv_store
	import mwce_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nvErase,
	input  wire logic              imgWr,
	input  wire mwce_image_s       imgIn,
	input  wire logic              byteWr,
	input  wire logic [MEM_AW-1:0] byteAddr,
	input  wire logic [7:0]        byteIn,
	output mwce_image_s            imgOut,
	output logic [7:0]             byteOut
);
	logic [7:0] store [MEM_DEPTH];

	// This store has no reset on purpose: it must outlive a power cycle.
	always_ff @(posedge sys_clk) begin
		if (nvErase) begin
			imgOut.recog <= RECOG_BLANK;
			imgOut.count <= COUNT_RESET;
		end else if (imgWr) begin
			imgOut <= imgIn;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (byteWr) begin
			store[byteAddr] <= byteIn;
		end
	end

	assign byteOut = store[byteAddr];

endmodule : mwce_nv_store

// ### mwce_top.sv
// Macro word command expander: token parser, macro store and expansion.
`timescale 1ns/10ps
module mwce_top
	import mwce_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic [7:0] inChar,
	input  wire logic       inValid,
	output logic            inReady,
	output logic [7:0]      cmdChar,
	output logic            cmdValid,
	input  wire logic       cmdReady,
	input  wire logic       execBusy,
	output logic [7:0]      lstChar,
	output logic            lstValid,
	input  wire logic       lstReady,
	output logic            recogOn,
	output logic            defError,
	input  wire logic       nvErase
);
	typedef enum logic [3:0] {ST_LOAD, ST_IDLE, ST_TOKEN, ST_NATIVE,
		ST_APPEND, ST_EMIT, ST_DELIM, ST_WAIT, ST_LIST, ST_SAVE} mwce_state_e;

	mwce_state_e            state;
	logic [63:0]            tok;
	logic [3:0]             tokLen;
	logic [7:0]             delim;
	logic                   defining, nameNext, markNext, defDrop;
	logic                   tokHeld, pendValid, lineActive, waitAfter;
	logic                   waitSeen, wildUsed, listTail, newWild, emSub;
	logic [SLOT_W-1:0]      pendSlot, emSlot, hitSlot, listSlot;
	logic [3:0]             count, listByte;
	logic [63:0]            newName;
	logic [5:0]             newLen, emIdx, emLen;
	logic [2:0]             nIdx, lIdx;
	logic [15:0]            optTok;
	logic [1:0]             optLen;
	logic [MEM_AW:0]        copyIdx;
	mwce_slot_s [NSLOT-1:0] slots;
	logic [7:0]             body [MEM_DEPTH];
	mwce_image_s            nvImg, saveImg;
	logic [7:0]             nvByte, emByte, nByte, nameByte, cmdNext, lstNext;
	logic                   hit, hasExec, isNum, anyKw, isDelimIn;
	logic                   isDefine, isOn, isOff, isSave, isList, isPurge;
	logic                   isStatus, cmdCan, lstCan, cmdPush, lstPush;
	logic                   isWildByte, optFirst, roomLeft, bodyWr, overflow;
	logic                   imgWr, byteWr;
	logic [MEM_AW-1:0]      bodyAddr;
	logic [7:0]             bodyData;

	// ****************************************************************
	// Token classification
	// ****************************************************************
	assign isDefine = tok == KW_DEFINE;
	assign isOn     = tok == KW_MARK_ON;
	assign isOff    = tok == KW_RECOG_OFF;
	assign isSave   = tok == KW_SAVE;
	assign isList   = tok == KW_LIST;
	assign isPurge  = tok == KW_PURGE;
	assign isStatus = (tok == KW_STATUS_SEL) || (tok == KW_STATUS_SX);
	assign anyKw    = isDefine | isOn | isOff | isSave | isList | isPurge;
	assign isNum = (tokLen == 4'h1 || tokLen == 4'h2)
		&& tok[7:0] >= CH_ZERO && tok[7:0] <= CH_NINE
		&& (tokLen == 4'h1 || (tok[15:8] >= CH_ZERO && tok[15:8] <= CH_NINE));
	assign isDelimIn = inChar == CH_SP || inChar == CH_CR
		|| inChar == CH_LF || inChar == CH_SEMI;

	always_comb begin
		hit = 1'b0;
		hitSlot = '0;
		hasExec = 1'b0;
		for (int i = 0; i < NSLOT; i++) begin
			if (i < count && slots[i].name == tok && !hit) begin
				hit = 1'b1;
				hitSlot = SLOT_W'(i);
			end
			if (tok[8*i +: 8] == CH_EXEC) begin
				hasExec = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Byte sources and output pushes
	// ****************************************************************
	assign emLen      = slots[emSlot].len;
	assign emByte     = body[{emSlot, emIdx[BODY_AW-1:0]}];
	assign nByte      = tok[8*nIdx +: 8];
	assign lIdx       = 3'(listByte - 4'h1);
	assign nameByte   = slots[listSlot].name[8*lIdx +: 8];
	assign isWildByte = emByte == CH_WILD;
	// only the first wildcard takes the option.
	assign optFirst   = isWildByte && !wildUsed && optLen != 2'h0;
	assign cmdCan     = !cmdValid || cmdReady;
	assign lstCan     = !lstValid || lstReady;
	assign roomLeft   = newLen != BODY_FULL;
	assign inReady    = state == ST_IDLE;

	always_comb begin
		cmdPush = 1'b0;
		cmdNext = emByte;
		if (state == ST_NATIVE && !defining) begin
			cmdPush = cmdCan;
			cmdNext = nByte;
		end else if (state == ST_EMIT && emIdx != emLen) begin
			cmdPush = cmdCan;
			if (optFirst) begin
				cmdNext = optTok[8*emSub +: 8];
			end else if (isWildByte) begin
				cmdNext = CH_ZERO;
			end
		end
	end

	always_comb begin
		lstPush = 1'b0;
		lstNext = CH_LF;
		if (state == ST_LIST && count != COUNT_RESET && lstCan) begin
			if (listTail) begin
				lstPush = 1'b1;
			end else if (listByte == 4'h0) begin
				lstPush = 1'b1;
				lstNext = CH_SP;
			end else if (nameByte != CH_NUL) begin
				lstPush = 1'b1;
				lstNext = nameByte;
			end
		end
	end

	assign bodyWr = defining && !defDrop && roomLeft
		&& (state == ST_NATIVE || (state == ST_APPEND && emIdx != emLen));
	assign overflow = defining && !defDrop && !roomLeft
		&& (state == ST_NATIVE || (state == ST_APPEND && emIdx != emLen));
	assign bodyAddr = {count[SLOT_W-1:0], newLen[BODY_AW-1:0]};
	assign bodyData = (state == ST_NATIVE) ? nByte : emByte;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cmdValid <= 1'b0;
			cmdChar <= CH_NUL;
		end else if (cmdPush) begin
			cmdValid <= 1'b1;
			cmdChar <= cmdNext;
		end else if (cmdReady) begin
			cmdValid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lstValid <= 1'b0;
			lstChar <= CH_NUL;
		end else if (lstPush) begin
			lstValid <= 1'b1;
			lstChar <= lstNext;
		end else if (lstReady) begin
			lstValid <= 1'b0;
		end
	end

	// ****************************************************************
	// Working memory and nonvolatile copy
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (state == ST_LOAD && !copyIdx[MEM_AW]) begin
			body[copyIdx[MEM_AW-1:0]] <= nvByte;
		end else if (bodyWr) begin
			body[bodyAddr] <= bodyData;
		end
	end

	assign imgWr   = state == ST_SAVE && copyIdx == '0;
	assign byteWr  = state == ST_SAVE && !copyIdx[MEM_AW];
	assign saveImg = {recogOn, count, slots};

	mwce_nv_store u_nv (
		.sys_clk  (sys_clk),
		.nvErase  (nvErase),
		.imgWr    (imgWr),
		.imgIn    (saveImg),
		.byteWr   (byteWr),
		.byteAddr (copyIdx[MEM_AW-1:0]),
		.byteIn   (body[copyIdx[MEM_AW-1:0]]),
		.imgOut   (nvImg),
		.byteOut  (nvByte)
	);

	// ****************************************************************
	// Parser and sequencer
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= ST_LOAD;
			{tok, newName, optTok} <= '0;
			{tokLen, listByte, count} <= '0;
			{newLen, emIdx, nIdx, optLen, copyIdx} <= '0;
			{pendSlot, emSlot, listSlot} <= '0;
			{defining, nameNext, markNext, defDrop, tokHeld} <= '0;
			{pendValid, lineActive, waitAfter, waitSeen} <= '0;
			{wildUsed, listTail, newWild, emSub, defError} <= '0;
			delim <= CH_SP;
			slots <= '0;
			recogOn <= RECOG_BLANK;
		end else begin
			defError <= 1'b0;
			case (state)
			ST_LOAD: begin
				if (copyIdx == '0) begin
					count <= nvImg.count;
					slots <= nvImg.slots;
					recogOn <= nvImg.recog;
				end
				if (copyIdx[MEM_AW]) begin
					copyIdx <= '0;
					state <= ST_IDLE;
				end else begin
					copyIdx <= copyIdx + 1'b1;
				end
			end
			ST_IDLE: begin
				if (inValid && isDelimIn) begin
					delim <= inChar;
					state <= (tokLen != 4'h0) ? ST_TOKEN : ST_DELIM;
				end else if (inValid) begin
					// Long tokens keep only their last eight characters.
					tok <= {tok[55:0], inChar};
					if (tokLen != TOK_FULL) begin
						tokLen <= tokLen + 4'h1;
					end
				end
			end
			ST_TOKEN: begin
				state <= ST_DELIM;
				if (pendValid) begin
					emSlot <= pendSlot;
					pendValid <= 1'b0;
					emIdx <= '0;
					wildUsed <= 1'b0;
					state <= ST_EMIT;
					if (isNum && slots[pendSlot].wild) begin
						optTok <= tok[15:0];
						optLen <= tokLen[1:0];
						emSub <= tokLen == 4'h2;
					end else begin
						optLen <= 2'h0;
						tokHeld <= 1'b1;
					end
				end else if (isDefine) begin
					recogOn <= 1'b1;
					if (defining) begin
						defDrop <= 1'b1;
						defError <= 1'b1;
					end
					defining <= 1'b1;
					nameNext <= ~defining;
				end else if (defining && nameNext) begin
					// names never hold the execute character.
					if (hit || hasExec || count == 4'(NSLOT)) begin
						defDrop <= 1'b1;
						defError <= 1'b1;
					end
					newName <= tok;
					newLen <= '0;
					newWild <= 1'b0;
					nameNext <= 1'b0;
				end else if (isOn) begin
					recogOn <= 1'b1;
					markNext <= defining;
				end else if (defining && anyKw) begin
					defDrop <= 1'b1;
					defError <= 1'b1;
				end else if (isOff) begin
					recogOn <= 1'b0;
				end else if (isSave) begin
					copyIdx <= '0;
					state <= ST_SAVE;
				end else if (isList || (isStatus && !defining)) begin
					listSlot <= 3'(count - 4'h1);
					listByte <= TOK_FULL;
					listTail <= 1'b0;
					state <= ST_LIST;
				end else if (isPurge) begin
					count <= COUNT_RESET;
				end else if (defining && markNext) begin
					markNext <= 1'b0;
					emSlot <= hitSlot;
					emIdx <= '0;
					if (hit) begin
						state <= ST_APPEND;
					end else begin
						defDrop <= 1'b1;
						defError <= 1'b1;
					end
				end else if (!defining && recogOn && hit) begin
					// macro deferred until its option is known.
					pendValid <= 1'b1;
					pendSlot <= hitSlot;
					lineActive <= 1'b1;
				end else if (!defDrop) begin
					// unmatched or off mode goes native.
					nIdx <= 3'(tokLen - 4'h1);
					lineActive <= lineActive | ~defining;
					state <= ST_NATIVE;
				end
			end
			ST_NATIVE: begin
				if (defining || cmdCan) begin
					if (nIdx == 3'h0) begin
						state <= ST_DELIM;
					end else begin
						nIdx <= nIdx - 3'h1;
					end
				end
			end
			ST_APPEND: begin
				if (emIdx == emLen || defDrop || !roomLeft) begin
					state <= ST_DELIM;
				end else begin
					emIdx <= emIdx + 6'h01;
				end
			end
			ST_EMIT: begin
				if (emIdx == emLen) begin
					tokHeld <= 1'b0;
					state <= tokHeld ? ST_TOKEN : ST_DELIM;
				end else if (cmdCan) begin
					if (optFirst && emSub) begin
						emSub <= 1'b0;
					end else begin
						emIdx <= emIdx + 6'h01;
						wildUsed <= wildUsed | isWildByte;
					end
				end
			end
			ST_DELIM: begin
				tok <= '0;
				tokLen <= 4'h0;
				waitSeen <= 1'b0;
				if (pendValid && delim == CH_LF) begin
					emSlot <= pendSlot;
					pendValid <= 1'b0;
					optLen <= 2'h0;
					emIdx <= '0;
					wildUsed <= 1'b0;
					state <= ST_EMIT;
				end else if (waitAfter) begin
					waitAfter <= 1'b0;
					state <= ST_WAIT;
				end else begin
					state <= ST_IDLE;
					if (delim == CH_SEMI && defining) begin
						if (!defDrop && !nameNext) begin
							slots[count[SLOT_W-1:0]] <= {newName, newLen, newWild};
							count <= count + 4'h1;
						end
						{defining, defDrop, markNext, nameNext} <= '0;
					end
					// line feed closes a macro line.
					if (delim == CH_LF) begin
						markNext <= 1'b0;
						lineActive <= 1'b0;
						if (lineActive) begin
							state <= ST_WAIT;
						end
					end
				end
			end
			ST_WAIT: begin
				// bus held until the expansion has run.
				waitSeen <= 1'b1;
				if (waitSeen && !cmdValid && !execBusy) begin
					state <= ST_DELIM;
				end
			end
			ST_LIST: begin
				if (count == COUNT_RESET || (listTail && lstCan)) begin
					state <= ST_DELIM;
				end else if (listByte != 4'h0) begin
					if (nameByte == CH_NUL || lstCan) begin
						listByte <= listByte - 4'h1;
					end
				end else if (!listTail && lstCan) begin
					listByte <= TOK_FULL;
					if (listSlot == '0) begin
						listTail <= 1'b1;
					end else begin
						listSlot <= listSlot - 1'b1;
					end
				end
			end
			ST_SAVE: begin
				if (copyIdx[MEM_AW]) begin
					copyIdx <= '0;
					state <= ST_DELIM;
				end else begin
					copyIdx <= copyIdx + 1'b1;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
			if (bodyWr) begin
				newLen <= newLen + 6'h01;
				newWild <= newWild | (bodyData == CH_WILD);
			end
			if (overflow) begin
				defDrop <= 1'b1;
				defError <= 1'b1;
			end
			if (cmdPush && cmdNext == CH_EXEC) begin
				waitAfter <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_hold_wait:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_WAIT |-> !inReady ##1 !inReady)
		else $error("Bus not held off while waiting.");
	chk_define_on:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_TOKEN && !pendValid && isDefine |=> recogOn)
		else $error("Define word left recognition off.");
	chk_purge_all:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_TOKEN && !pendValid && !defining && isPurge
		|=> count == COUNT_RESET)
		else $error("Purge left macros in memory.");
	chk_save_mode:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		imgWr && !nvErase |=> nvImg.recog == $past(recogOn))
		else $error("Saved mode differs from current mode.");
	chk_save_count:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		imgWr && !nvErase |=> nvImg.count == $past(count))
		else $error("Saved macro count differs.");
	chk_list_empty:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_LIST && count == COUNT_RESET
		|-> !lstPush ##1 (state == ST_DELIM && !lstValid))
		else $error("Empty store produced list output.");
	chk_list_first:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state != ST_LIST ##1 state == ST_LIST
		|-> listSlot == 3'(count - 4'h1))
		else $error("Listing did not start at newest macro.");
	chk_wild_zero:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		cmdPush && state == ST_EMIT && isWildByte && wildUsed
		|=> cmdValid && cmdChar == CH_ZERO)
		else $error("Later wildcard not given option zero.");
	chk_wild_first:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		cmdPush && state == ST_EMIT && optFirst && !emSub
		|=> cmdChar == optTok[7:0] ##1 wildUsed)
		else $error("First wildcard did not get the option.");
	chk_off_native:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_TOKEN && !recogOn && !pendValid && !defining
		&& !anyKw && !isStatus |=> state == ST_NATIVE)
		else $error("Macro recognised while recognition off.");
	chk_keep_parts:
	assert property (@(posedge sys_clk) disable iff (!rstn)
		state == ST_DELIM && delim == CH_SEMI && defining && !defDrop
		&& !nameNext && !waitAfter && !pendValid
		|=> count == $past(count) + 4'h1
		&& ($past(count) == COUNT_RESET || $stable(slots[0].name)))
		else $error("Commit lost or disturbed a macro.");

endmodule : mwce_top

// ### mwce_exec_model.sv
// Behavioural model of the native command executor and the listing sink.
`timescale 1ns/10ps
module mwce_exec_model
	import mwce_pkg::*;
#(
	parameter int BUSY_CYC = 6
)
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       slow,
	input  wire logic [7:0] cmdChar,
	input  wire logic       cmdValid,
	output logic            cmdReady,
	output logic            execBusy,
	input  wire logic       lstValid,
	output logic            lstReady
);
	logic       phase   = 1'b0;
	logic [7:0] busyCnt = 8'h00;

	assign execBusy = (busyCnt != 8'h00);
	// A busy executor takes no command characters, so the expander has to wait for it.
	assign cmdReady = !execBusy && (!slow || phase);
	assign lstReady = !slow || !phase;

	always @(posedge sys_clk) begin
		phase <= !phase;
		if (!rstn) begin
			busyCnt <= 8'h00;
		end else if (cmdValid && cmdReady && cmdChar == CH_EXEC) begin
			busyCnt <= 8'(BUSY_CYC);
		end else if (busyCnt != 8'h00) begin
			busyCnt <= busyCnt - 8'h01;
		end
	end
endmodule : mwce_exec_model

// ### test_macro_word_command_expander.sv
// Self-checking bench of the macro word command expander.
`timescale 1ns/10ps
module test_macro_word_command_expander
	import mwce_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       rstn    = 1'b0;
	logic [7:0] inChar  = 8'h00;
	logic       inValid = 1'b0;
	logic       nvErase = 1'b1;
	logic       slow    = 1'b0;
	logic       inReady, cmdValid, cmdReady, execBusy;
	logic       lstValid, lstReady, recogOn, defError;
	logic [7:0] cmdChar, lstChar;
	logic [7:0] cmdLog[$];
	logic [7:0] lstLog[$];
	int         n_mismatch  = 0;
	int         check_count = 0;
	int         nDefErr     = 0;
	string      all6 = "TT FL FN SC SB SA \n";

	always #10 sys_clk = ~sys_clk;

	mwce_top dut (.sys_clk(sys_clk), .rstn(rstn), .inChar(inChar),
		.inValid(inValid), .inReady(inReady), .cmdChar(cmdChar),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .execBusy(execBusy),
		.lstChar(lstChar), .lstValid(lstValid), .lstReady(lstReady),
		.recogOn(recogOn), .defError(defError), .nvErase(nvErase));

	mwce_exec_model partner (.sys_clk(sys_clk), .rstn(rstn), .slow(slow),
		.cmdChar(cmdChar), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.execBusy(execBusy), .lstValid(lstValid), .lstReady(lstReady));

	// ************************************************************
	// Checking helpers
	// ************************************************************
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : check

	// Handshakes are sampled at the falling edge, where all is settled.
	always @(negedge sys_clk) begin
		if (cmdValid === 1'b1 && cmdReady === 1'b1) cmdLog.push_back(cmdChar);
		if (lstValid === 1'b1 && lstReady === 1'b1) lstLog.push_back(lstChar);
		if (execBusy === 1'b1) check(64'(inReady), 64'h0);
		if (defError === 1'b1) nDefErr++;
	end

	task automatic cmp(ref logic [7:0] q[$], input string s);
		check(64'(q.size()), 64'(s.len()));
		foreach (q[i]) if (i < s.len()) check(64'(q[i]), 64'(s[i]));
		q = {};
	endtask : cmp

	function automatic string kw(input logic [63:0] w);
		string s;
		s = "";
		for (int i = 7; i >= 0; i--)
			if (w[i*8 +: 8] != 8'h00) s = $sformatf("%s%c", s, w[i*8 +: 8]);
		return s;
	endfunction : kw

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// ************************************************************
	// Bus driving
	// ************************************************************
	task automatic put(input logic [7:0] c);
		inChar  <= c;
		inValid <= 1'b1;
		for (int n = 0; n < 3000; n++) begin
			@(negedge sys_clk);
			if (inReady === 1'b1) break;
		end
		@(posedge sys_clk);
	endtask : put

	task automatic settle();
		int q;
		q = 0;
		for (int n = 0; n < 3000 && q < 4; n++) begin
			@(negedge sys_clk);
			if (inReady === 1'b1 && cmdValid === 1'b0 && lstValid === 1'b0
				&& execBusy === 1'b0) q++;
			else q = 0;
		end
		if (q < 4) check(64'h0, 64'h1);
		@(posedge sys_clk);
	endtask : settle

	task automatic line(input string s);
		string t;
		t = {s, "\r\n"};
		for (int i = 0; i < t.len(); i++) put(8'(t[i]));
		inValid <= 1'b0;
		settle();
	endtask : line

	task automatic def(input string name, input string body);
		line({kw(KW_DEFINE), " ", name, " ", body, " ;"});
	endtask : def

	task automatic do_reset(input logic erase);
		rstn    <= 1'b0;
		nvErase <= erase;
		repeat (16) @(posedge sys_clk);
		rstn    <= 1'b1;
		nvErase <= 1'b0;
		settle();
	endtask : do_reset

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_combine();
		string m;
		m = kw(KW_MARK_ON);
		slow <= 1'b1;
		line(kw(KW_LIST));
		cmp(lstLog, "");
		def("SA", "F1X");
		def("SB", "R0X");
		def("SC", {m, " SA ", m, " SB P1Z1X"});
		cmp(cmdLog, "");
		line("SC");
		cmp(cmdLog, "F1XR0XP1Z1X");
		line("SA");
		cmp(cmdLog, "F1X");
		slow <= 1'b0;
	endtask : t_combine

	task automatic t_wild();
		string m;
		m = kw(KW_MARK_ON);
		def("FN", "F$X");
		def("FL", "P$X");
		def("TT", {m, " FN ", m, " FL"});
		line("TT 3");
		cmp(cmdLog, "F3XP0X");
		line("FN 2 P1Z1X");
		cmp(cmdLog, "F2XP1Z1X");
		line("FN 12 FN SA");
		cmp(cmdLog, "F12XF0XF1X");
	endtask : t_wild

	task automatic t_reject();
		def("XB", "F1X");
		check(64'(nDefErr), 64'h1);
		def("SA", "R1X");
		line("SA");
		cmp(cmdLog, "F1X");
		check(64'(nDefErr), 64'h2);
	endtask : t_reject

	task automatic t_list();
		line(kw(KW_LIST));
		cmp(lstLog, all6);
		line(kw(KW_STATUS_SEL));
		cmp(lstLog, all6);
		line(kw(KW_STATUS_SX));
		cmp(lstLog, all6);
	endtask : t_list

	task automatic t_save();
		line(kw(KW_RECOG_OFF));
		check(64'(recogOn), 64'h0);
		line("SA");
		cmp(cmdLog, "SA");
		line(kw(KW_SAVE));
		do_reset(1'b0);
		check(64'(recogOn), 64'h0);
		line(kw(KW_LIST));
		cmp(lstLog, all6);
		def("SD", "F2X");
		check(64'(recogOn), 64'h1);
		line("SD");
		cmp(cmdLog, "F2X");
	endtask : t_save

	task automatic t_purge();
		line(kw(KW_PURGE));
		line(kw(KW_LIST));
		cmp(lstLog, "");
		do_reset(1'b0);
		line(kw(KW_LIST));
		cmp(lstLog, all6);
		line(kw(KW_PURGE));
		line(kw(KW_SAVE));
		do_reset(1'b0);
		line(kw(KW_LIST));
		cmp(lstLog, "");
	endtask : t_purge

	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		test_done();
	end

	initial begin
		do_reset(1'b1);
		t_combine();
		t_wild();
		t_reject();
		t_list();
		t_save();
		t_purge();
		test_done();
	end
endmodule : test_macro_word_command_expander
